// ### fes_pkg.sv
package fes_pkg;
	localparam logic [7:0] SECTOR_ERASE_OP = 8'h7c;
	localparam logic [7:0] CHIP_ERASE_B0 = 8'hc7;
	localparam logic [7:0] CHIP_ERASE_B1 = 8'h94;
	localparam logic [7:0] CHIP_ERASE_B2 = 8'h80;
	localparam logic [7:0] CHIP_ERASE_B3 = 8'h9a;
	localparam logic [7:0] SUSPEND_OP = 8'hb0;
	localparam logic [7:0] STATUS_OP = 8'hd7;
	localparam logic [7:0] READ_OP = 8'h03;
	localparam logic [7:0] PROG_BUF1_OP = 8'h88;
	localparam logic [7:0] PROG_BUF2_OP = 8'h89;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [7:0] PROGRAMMED_BYTE = 8'h00;
	localparam logic [7:0] UNDEF_BYTE = 8'ha5;
	localparam int NUM_SECTORS = 17;
	localparam int STAT_READY_BIT = 7;
	localparam int STAT_EPE_BIT = 5;
	localparam int STAT_ES_BIT = 2;
	localparam int STAT_PS2_BIT = 1;
	localparam int STAT_PS1_BIT = 0;
	// timing
	localparam int CORE_CLK_PERIOD_NS = 20;
	localparam int SECTOR_ERASE_TIME_US = 1000;
	localparam int CHIP_ERASE_TIME_US = 8000;
	localparam int SUSPEND_LATENCY_US = 20;
	localparam int SECTOR_ERASE_CYCLES = SECTOR_ERASE_TIME_US * 1000 / CORE_CLK_PERIOD_NS;
	localparam int CHIP_ERASE_CYCLES = CHIP_ERASE_TIME_US * 1000 / CORE_CLK_PERIOD_NS;
	localparam int SUSPEND_CYCLES = SUSPEND_LATENCY_US * 1000 / CORE_CLK_PERIOD_NS;
	localparam int LINK_PERIOD_NS = 160;
	localparam int HALF_PERIOD_CYCLES = LINK_PERIOD_NS / (2 * CORE_CLK_PERIOD_NS);
	// host registers and command kinds
	localparam logic [3:0] CTRL_OFFSET = 4'h0;
	localparam logic [3:0] PAGE_OFFSET = 4'h4;
	localparam logic [3:0] STAT_OFFSET = 4'h8;
	localparam logic [2:0] K_STATUS = 3'h0;
	localparam logic [2:0] K_READ = 3'h1;
	localparam logic [2:0] K_SECT = 3'h2;
	localparam logic [2:0] K_CHIP = 3'h3;
	localparam logic [2:0] K_SUSP = 3'h4;
	localparam logic [2:0] K_PROG1 = 3'h5;
	localparam logic [2:0] K_PROG2 = 3'h6;
	localparam int CTRL_WAIT_BIT = 3;
	localparam int CTRL_BIN_BIT = 4;

	function automatic logic [11:0] page_of(input logic [23:0] a, input logic bin);
		return bin ? a[20:9] : a[21:10];
	endfunction

	function automatic logic [23:0] addr_of(input logic [11:0] p, input logic bin);
		return bin ? {3'h0, p, 9'h000} : {2'h0, p, 10'h000};
	endfunction

	// index 0 is 0a, 1 is 0b, n+1 is sector n
	function automatic logic [4:0] sector_of(input logic [11:0] p);
		if (p[11:8] == 4'h0) begin
			return (p[7:3] == 5'h00) ? 5'h00 : 5'h01;
		end
		return {1'b0, p[11:8]} + 5'h01;
	endfunction

	// 528 mode skips the hole above byte 527 of each page
	function automatic logic [23:0] next_addr(input logic [23:0] a, input logic bin);
		if (!bin && a[9:0] == 10'h20f) begin
			return {a[23:10] + 14'h0001, 10'h000};
		end
		return a + 24'h000001;
	endfunction
endpackage

// ### fes_link_if.sv
`timescale 1ns/1ns
interface fes_link_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso;
	logic miso_oe;
	logic miso_line;
	// undriven serial output floats high through the pull-up
	assign miso_line = miso_oe ? miso : 1'b1;
	modport host(output sclk, output cs_n, output mosi, input miso_line);
	modport dev(input sclk, input cs_n, input mosi, output miso, output miso_oe);
endinterface

// ### fes_pin_sync.sv
`timescale 1ns/1ns
module fes_pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	// two stages; first stage feeds only the second
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_reg <= '1;
			sync_out <= '1;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

// ### fes_dev.sv
`timescale 1ns/1ns
module fes_dev import fes_pkg::*; #(
	parameter int SE_CYCLES = SECTOR_ERASE_CYCLES,
	parameter int CE_CYCLES = CHIP_ERASE_CYCLES,
	parameter int SUSP_CYCLES = SUSPEND_CYCLES
) (
	fes_link_if.dev link,
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [NUM_SECTORS-1:0] sector_protect,
	input wire logic [NUM_SECTORS-1:0] sector_lock,
	input wire logic wp_n,
	input wire logic reset_pin_n,
	input wire logic page_mode_binary,
	input wire logic erase_fault_inject,
	output logic [7:0] status_byte,
	output logic [NUM_SECTORS-1:0] sector_erased
);
	typedef enum {OP_IDLE, OP_SECT, OP_CHIP, OP_PROG1, OP_PROG2} fes_op_type;
	localparam int SYNC_W = 2 * NUM_SECTORS + 7;

	logic [SYNC_W-1:0] sync_vec;
	logic [NUM_SECTORS-1:0] s_prot, s_lock;
	logic s_wp_n, s_rst_n, s_bin, s_fault, s_sclk, s_cs_n, s_mosi;
	logic sclk_d_reg, cs_d_reg;
	logic sclk_rise, sclk_fall, cs_rise, byte_done, exec_ok;
	logic [2:0] bit_cnt_reg, byte_cnt_reg;
	logic [7:0] shift_reg, cmd_reg, tx_reg, rx_byte, cur_cmd, status_next;
	logic [23:0] addr_reg;
	logic chip_ok_reg, oe_reg;
	fes_op_type op_reg;
	logic [31:0] timer_reg, susp_timer_reg;
	logic [4:0] op_sector_reg, es_sector_reg, ps_sector_reg, cmd_sector;
	logic susp_pend_reg, fault_reg, epe_reg, es_reg, ps1_reg, ps2_reg, wp_active_reg;
	logic [NUM_SECTORS-1:0] prot_eff, chip_prot_reg, erased_reg;
	logic idle, running, op_done, susp_done, rst_pin, cmd_full, any_susp;
	logic start_sect, start_chip, start_prog, start_susp;

	fes_pin_sync #(.WIDTH(SYNC_W)) u_sync (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.async_in({sector_protect, sector_lock, wp_n, reset_pin_n, page_mode_binary,
			erase_fault_inject, link.sclk, link.cs_n, link.mosi}),
		.sync_out(sync_vec)
	);
	assign {s_prot, s_lock, s_wp_n, s_rst_n, s_bin, s_fault, s_sclk, s_cs_n, s_mosi} = sync_vec;

	// edge finding on the sampled link clock and select
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sclk_d_reg <= 1'b0;
			cs_d_reg <= 1'b1;
		end else begin
			sclk_d_reg <= s_sclk;
			cs_d_reg <= s_cs_n;
		end
	end
	assign sclk_rise = s_sclk & ~sclk_d_reg & ~s_cs_n;
	assign sclk_fall = ~s_sclk & sclk_d_reg & ~s_cs_n;
	assign cs_rise = s_cs_n & ~cs_d_reg;
	assign byte_done = sclk_rise & (bit_cnt_reg == 3'h7);
	assign rx_byte = {shift_reg[6:0], s_mosi};
	assign cur_cmd = (byte_cnt_reg == 3'h0) ? rx_byte : cmd_reg;
	// an incomplete last byte cancels the command
	assign exec_ok = cs_rise & (bit_cnt_reg == 3'h0);
	assign cmd_full = byte_cnt_reg >= 3'h4;

	// bit and byte framing; byte count saturates so trailing bytes fall away
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			bit_cnt_reg <= 3'h0;
			byte_cnt_reg <= 3'h0;
			shift_reg <= 8'h00;
		end else if (s_cs_n) begin
			bit_cnt_reg <= 3'h0;
			byte_cnt_reg <= 3'h0;
		end else if (sclk_rise) begin
			shift_reg <= rx_byte;
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			if (bit_cnt_reg == 3'h7 && byte_cnt_reg != 3'h7) begin
				byte_cnt_reg <= byte_cnt_reg + 3'h1;
			end
		end
	end

	// opcode, address and chip erase sequence capture
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_reg <= 8'h00;
			addr_reg <= 24'h000000;
			chip_ok_reg <= 1'b0;
		end else if (byte_done) begin
			case (byte_cnt_reg)
				3'h0: begin
					cmd_reg <= rx_byte;
					chip_ok_reg <= rx_byte == CHIP_ERASE_B0;
				end
				3'h1: begin
					addr_reg[23:16] <= rx_byte;
					chip_ok_reg <= chip_ok_reg & (rx_byte == CHIP_ERASE_B1);
				end
				3'h2: begin
					addr_reg[15:8] <= rx_byte;
					chip_ok_reg <= chip_ok_reg & (rx_byte == CHIP_ERASE_B2);
				end
				3'h3: begin
					addr_reg[7:0] <= rx_byte;
					chip_ok_reg <= chip_ok_reg & (rx_byte == CHIP_ERASE_B3);
				end
				default: begin
					if (cmd_reg == READ_OP) begin
						addr_reg <= next_addr(addr_reg, s_bin);
					end
				end
			endcase
		end
	end

	// array data as seen from outside
	function automatic logic [7:0] array_byte(input logic [23:0] a);
		logic [4:0] s;
		s = sector_of(page_of(a, s_bin));
		if ((es_reg && es_sector_reg == s) || ((ps1_reg || ps2_reg) && ps_sector_reg == s)) begin
			return UNDEF_BYTE;
		end
		return erased_reg[s] ? ERASED_BYTE : PROGRAMMED_BYTE;
	endfunction

	// output shifter: loaded at a byte end, shifted on falls inside a byte
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_reg <= 8'hff;
			oe_reg <= 1'b0;
		end else begin
			oe_reg <= ~s_cs_n;
			if (byte_done && cur_cmd == STATUS_OP) begin
				tx_reg <= status_next;
			end else if (byte_done && cmd_reg == READ_OP && byte_cnt_reg == 3'h3) begin
				tx_reg <= array_byte({addr_reg[23:8], rx_byte});
			end else if (byte_done && cmd_reg == READ_OP && cmd_full) begin
				tx_reg <= array_byte(next_addr(addr_reg, s_bin));
			end else if (sclk_fall && bit_cnt_reg != 3'h0) begin
				tx_reg <= {tx_reg[6:0], 1'b1};
			end
		end
	end
	assign link.miso = tx_reg[7];
	assign link.miso_oe = oe_reg;

	// command launch when chip select rises
	assign cmd_sector = sector_of(page_of(addr_reg, s_bin));
	assign prot_eff = s_prot | s_lock | {NUM_SECTORS{wp_active_reg}};
	assign idle = (op_reg == OP_IDLE) & ~susp_pend_reg;
	assign any_susp = es_reg | ps1_reg | ps2_reg;
	assign start_sect = exec_ok & idle & ~any_susp & (cmd_reg == SECTOR_ERASE_OP) & cmd_full
		& ~prot_eff[cmd_sector];
	assign start_chip = exec_ok & idle & ~any_susp & chip_ok_reg & cmd_full;
	assign start_prog = exec_ok & idle & ~ps1_reg & ~ps2_reg & cmd_full
		& (cmd_reg == PROG_BUF1_OP || cmd_reg == PROG_BUF2_OP) & ~prot_eff[cmd_sector]
		& ~(es_reg && es_sector_reg == cmd_sector);
	assign start_susp = exec_ok & (cmd_reg == SUSPEND_OP) & (byte_cnt_reg != 3'h0)
		& ~susp_pend_reg & (op_reg != OP_IDLE) & (op_reg != OP_CHIP);
	assign running = (op_reg != OP_IDLE) & ~susp_pend_reg;
	assign op_done = running & (timer_reg == 32'h0);
	assign susp_done = susp_pend_reg & (susp_timer_reg == 32'h0);
	assign rst_pin = ~s_rst_n;

	// self-timed operation and suspend countdown
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			op_reg <= OP_IDLE;
			timer_reg <= 32'h0;
			susp_timer_reg <= 32'h0;
			susp_pend_reg <= 1'b0;
			op_sector_reg <= 5'h00;
			fault_reg <= 1'b0;
		end else if (rst_pin) begin
			op_reg <= OP_IDLE;
			susp_pend_reg <= 1'b0;
		end else if (start_sect || start_prog) begin
			op_reg <= start_sect ? OP_SECT : (cmd_reg == PROG_BUF1_OP) ? OP_PROG1 : OP_PROG2;
			op_sector_reg <= cmd_sector;
			timer_reg <= 32'(SE_CYCLES - 1);
			fault_reg <= 1'b0;
		end else if (start_chip) begin
			op_reg <= OP_CHIP;
			timer_reg <= 32'(CE_CYCLES - 1);
			fault_reg <= 1'b0;
		end else if (susp_done) begin
			op_reg <= OP_IDLE;
			susp_pend_reg <= 1'b0;
		end else if (susp_pend_reg) begin
			susp_timer_reg <= susp_timer_reg - 32'h1;
		end else if (start_susp) begin
			susp_pend_reg <= 1'b1;
			susp_timer_reg <= 32'(SUSP_CYCLES - 1);
		end else if (op_done) begin
			op_reg <= OP_IDLE;
		end else if (running) begin
			timer_reg <= timer_reg - 32'h1;
			fault_reg <= fault_reg | (s_fault & (op_reg == OP_SECT || op_reg == OP_CHIP));
		end
	end

	// status flags; error set beats start clear since start needs an idle device, reset pin clear beats suspend set
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			epe_reg <= 1'b0;
			es_reg <= 1'b0;
			ps1_reg <= 1'b0;
			ps2_reg <= 1'b0;
			es_sector_reg <= 5'h00;
			ps_sector_reg <= 5'h00;
		end else begin
			if (op_done && fault_reg) begin
				epe_reg <= 1'b1;
			end else if (start_sect || start_chip || start_prog) begin
				epe_reg <= 1'b0;
			end
			if (rst_pin) begin
				es_reg <= 1'b0;
				ps1_reg <= 1'b0;
				ps2_reg <= 1'b0;
			end else if (susp_done) begin
				case (op_reg)
					OP_SECT: begin
						es_reg <= 1'b1;
						es_sector_reg <= op_sector_reg;
					end
					OP_PROG1: begin
						ps1_reg <= 1'b1;
						ps_sector_reg <= op_sector_reg;
					end
					OP_PROG2: begin
						ps2_reg <= 1'b1;
						ps_sector_reg <= op_sector_reg;
					end
					default: begin
					end
				endcase
			end
		end
	end

	// write protect and chip erase protection only change between operations
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			wp_active_reg <= 1'b0;
			chip_prot_reg <= '0;
		end else begin
			if (op_reg == OP_IDLE) begin
				wp_active_reg <= ~s_wp_n;
			end
			if (start_chip) begin
				chip_prot_reg <= prot_eff;
			end
		end
	end

	// per-sector erased state; contents are unknown after power-up
	generate
		for (genvar i = 0; i < NUM_SECTORS; i++) begin : g_sector
			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					erased_reg[i] <= 1'b0;
				end else if (rst_pin && es_reg && es_sector_reg == 5'(i)) begin
					erased_reg[i] <= 1'b0;
				end else if (rst_pin && (ps1_reg || ps2_reg) && ps_sector_reg == 5'(i)) begin
					erased_reg[i] <= 1'b0;
				end else if (op_done && op_sector_reg == 5'(i)
					&& (op_reg == OP_PROG1 || op_reg == OP_PROG2)) begin
					erased_reg[i] <= 1'b0;
				end else if (op_done && !fault_reg && ((op_reg == OP_SECT
					&& op_sector_reg == 5'(i)) || (op_reg == OP_CHIP && !chip_prot_reg[i]))) begin
					erased_reg[i] <= 1'b1;
				end
			end
		end
	endgenerate

	// status byte
	always_comb begin
		status_next = 8'h00;
		status_next[STAT_READY_BIT] = op_reg == OP_IDLE;
		status_next[STAT_EPE_BIT] = epe_reg;
		status_next[STAT_ES_BIT] = es_reg;
		status_next[STAT_PS2_BIT] = ps2_reg;
		status_next[STAT_PS1_BIT] = ps1_reg;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			status_byte <= 8'h00;
			sector_erased <= '0;
		end else begin
			status_byte <= status_next;
			sector_erased <= erased_reg;
		end
	end
endmodule

// ### fes_host.sv
`timescale 1ns/1ns
module fes_host import fes_pkg::*; #(
	parameter int HALF = HALF_PERIOD_CYCLES
) (
	fes_link_if.host link,
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [3:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [3:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	typedef enum {H_IDLE, H_SEL, H_BIT, H_GAP} fes_hstate_type;
	fes_hstate_type st_reg;
	logic [4:0] ctrl_reg;
	logic [11:0] page_reg;
	logic poll_reg, sclk_reg, cs_n_reg, mosi_reg, s_miso;
	logic [7:0] rx_reg, cur_byte;
	logic [2:0] bit_reg, byte_reg, nbytes, kind_sel;
	logic [15:0] phase_reg;
	logic [23:0] a;
	logic wr_take, rd_take, start, last_bit;

	fes_pin_sync #(.WIDTH(1)) u_sync (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.async_in(link.miso_line),
		.sync_out(s_miso)
	);

	// bus handshakes; address and data are taken together
	assign wr_take = awvalid & wvalid & ~bvalid;
	assign awready = wr_take;
	assign wready = wr_take;
	assign rd_take = arvalid & ~rvalid;
	assign arready = rd_take;
	assign start = wr_take & (awaddr == CTRL_OFFSET) & wstrb[0] & (st_reg == H_IDLE);

	// register writes; orders arriving while busy are dropped
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_reg <= 5'h00;
			page_reg <= 12'h000;
			bvalid <= 1'b0;
			bresp <= 2'h0;
		end else begin
			if (start) begin
				ctrl_reg <= wdata[4:0];
			end
			if (wr_take && awaddr == PAGE_OFFSET) begin
				if (wstrb[0]) begin
					page_reg[7:0] <= wdata[7:0];
				end
				if (wstrb[1]) begin
					page_reg[11:8] <= wdata[11:8];
				end
			end
			if (wr_take) begin
				bvalid <= 1'b1;
				bresp <= (awaddr == CTRL_OFFSET || awaddr == PAGE_OFFSET) ? 2'h0 : 2'h2;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// register reads
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= 2'h0;
		end else if (rd_take) begin
			rvalid <= 1'b1;
			rresp <= 2'h0;
			case (araddr)
				CTRL_OFFSET: rdata <= {27'h0, ctrl_reg};
				PAGE_OFFSET: rdata <= {20'h0, page_reg};
				STAT_OFFSET: rdata <= {16'h0, rx_reg, 7'h0, st_reg != H_IDLE};
				default: begin
					rdata <= 32'h0;
					rresp <= 2'h2;
				end
			endcase
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// byte sequence for the command in hand; read dummy bits stay zero, the status dummy byte carries a[23:16]
	assign kind_sel = poll_reg ? K_STATUS : ctrl_reg[2:0];
	assign a = addr_of(page_reg, ctrl_reg[CTRL_BIN_BIT]);
	always_comb begin
		cur_byte = 8'h00;
		case (kind_sel)
			K_STATUS: nbytes = 3'h2;
			K_READ: nbytes = 3'h5;
			K_SUSP: nbytes = 3'h1;
			default: nbytes = 3'h4;
		endcase
		case (byte_reg)
			3'h0: begin
				case (kind_sel)
					K_STATUS: cur_byte = STATUS_OP;
					K_READ: cur_byte = READ_OP;
					K_SECT: cur_byte = SECTOR_ERASE_OP;
					K_CHIP: cur_byte = CHIP_ERASE_B0;
					K_SUSP: cur_byte = SUSPEND_OP;
					K_PROG1: cur_byte = PROG_BUF1_OP;
					default: cur_byte = PROG_BUF2_OP;
				endcase
			end
			3'h1: cur_byte = (kind_sel == K_CHIP) ? CHIP_ERASE_B1 : a[23:16];
			3'h2: cur_byte = (kind_sel == K_CHIP) ? CHIP_ERASE_B2 : a[15:8];
			3'h3: cur_byte = (kind_sel == K_CHIP) ? CHIP_ERASE_B3 : a[7:0];
			default: cur_byte = 8'h00;
		endcase
	end
	assign last_bit = phase_reg == 16'(2 * HALF - 1);

	// serial engine: mode 0, link clock divided from core clock
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= H_IDLE;
			poll_reg <= 1'b0;
			sclk_reg <= 1'b0;
			cs_n_reg <= 1'b1;
			mosi_reg <= 1'b0;
			rx_reg <= 8'h00;
			bit_reg <= 3'h0;
			byte_reg <= 3'h0;
			phase_reg <= 16'h0;
		end else begin
			case (st_reg)
				H_IDLE: begin
					if (start) begin
						// every command kind waits for ready when asked, status and read included
						poll_reg <= wdata[CTRL_WAIT_BIT];
						st_reg <= H_SEL;
						cs_n_reg <= 1'b0;
						phase_reg <= 16'h0;
						byte_reg <= 3'h0;
						bit_reg <= 3'h0;
					end
				end
				H_SEL: begin
					phase_reg <= phase_reg + 16'h1;
					if (phase_reg == 16'(HALF - 1)) begin
						st_reg <= H_BIT;
						phase_reg <= 16'h0;
					end
				end
				H_BIT: begin
					phase_reg <= last_bit ? 16'h0 : phase_reg + 16'h1;
					if (phase_reg == 16'h0) begin
						mosi_reg <= cur_byte[3'h7 - bit_reg];
					end
					if (phase_reg == 16'(HALF)) begin
						sclk_reg <= 1'b1;
					end
					if (last_bit) begin
						sclk_reg <= 1'b0;
						rx_reg <= {rx_reg[6:0], s_miso};
						bit_reg <= bit_reg + 3'h1;
						if (bit_reg == 3'h7) begin
							byte_reg <= byte_reg + 3'h1;
							if (byte_reg == nbytes - 3'h1) begin
								st_reg <= H_GAP;
								cs_n_reg <= 1'b1;
							end
						end
					end
				end
				H_GAP: begin
					phase_reg <= phase_reg + 16'h1;
					if (last_bit) begin
						phase_reg <= 16'h0;
						byte_reg <= 3'h0;
						if (poll_reg) begin
							// repeat the status read until ready
							poll_reg <= ~rx_reg[STAT_READY_BIT];
							st_reg <= H_SEL;
							cs_n_reg <= 1'b0;
						end else begin
							st_reg <= H_IDLE;
						end
					end
				end
				default: st_reg <= H_IDLE;
			endcase
		end
	end
	assign link.sclk = sclk_reg;
	assign link.cs_n = cs_n_reg;
	assign link.mosi = mosi_reg;
endmodule

// ### fes_link_props.sv
`timescale 1ns/1ns
module fes_link_props (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	logic [2:0] nbits_reg;
	// bit count of the frame, so its end can be tied to a byte
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			nbits_reg <= 3'h0;
		end else if (cs_n) begin
			nbits_reg <= 3'h0;
		end else if ($rose(sclk)) begin
			nbits_reg <= nbits_reg + 3'h1;
		end
	end
	// one high phase of the link clock, then a low
	sequence high_phase;
		sclk[*3] ##[1:2] !sclk;
	endsequence
	sequence quiet_gap;
		cs_n[*7];
	endsequence
	idle_low_a: assert property (cs_n |-> !sclk) else $error("clock outside frame");
	mosi_hold_a: assert property (sclk && $past(sclk) |-> $stable(mosi))
		else $error("mosi moved while clock high");
	clk_high_a: assert property ($rose(sclk) |-> high_phase) else $error("bad high phase");
	lead_in_a: assert property ($fell(cs_n) |-> !sclk[*3]) else $error("no lead-in");
	cs_gap_a: assert property ($rose(cs_n) |-> quiet_gap) else $error("select gap short");
	byte_end_a: assert property ($rose(cs_n) |-> nbits_reg == 3'h0)
		else $error("frame not on byte");
	// select rises at the very edge that ends the last high phase
	end_low_a: assert property ($rose(cs_n) |-> !sclk && $past(sclk))
		else $error("select not raised at clock fall");
	miso_release_a: assert property (cs_n[*6] |-> !miso_oe) else $error("miso still driven");
	miso_hold_a: assert property (miso_oe && sclk && $past(sclk) |-> $stable(miso))
		else $error("miso moved while clock high");
	// device drives its output only while selected, three samples late
	drive_window_a: assert property (miso_oe == !$past(cs_n, 3))
		else $error("miso driven outside select");
endmodule

// ### tb_top.sv
`timescale 1ns/1ns
module tb_top import fes_pkg::*; ();
	logic core_clk = 0;
	logic reset_n = 0;
	logic [3:0] awaddr = 4'h0;
	logic [3:0] araddr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 0;
	logic wvalid = 0;
	logic arvalid = 0;
	logic bready = 0;
	logic rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rdata, rd;
	logic [NUM_SECTORS-1:0] prot = '0;
	logic [NUM_SECTORS-1:0] lock = '0;
	logic [NUM_SECTORS-1:0] erased, exp;
	logic [7:0] stat;
	logic wp_n = 1;
	logic rpin_n = 1;
	logic bin = 0;
	logic fault = 0;
	int errors = 0;
	int n_checks = 0;
	fes_link_if link();
	// long counts cut down so suspends still land inside an erase or a program
	fes_dev #(.SE_CYCLES(2000), .CE_CYCLES(3000), .SUSP_CYCLES(5)) u_fes_dev(.link(link.dev),
		.core_clk(core_clk), .reset_n(reset_n), .sector_protect(prot), .sector_lock(lock),
		.wp_n(wp_n), .reset_pin_n(rpin_n), .page_mode_binary(bin), .erase_fault_inject(fault),
		.status_byte(stat), .sector_erased(erased));
	// response ready is raised with each request and dropped once the answer is seen
	fes_host u_fes_host(.link(link.host), .core_clk(core_clk), .reset_n(reset_n),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));
	fes_link_props u_fes_link_props(.core_clk(core_clk), .reset_n(reset_n), .sclk(link.sclk),
		.cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe));
	initial begin
		forever #10 core_clk = ~core_clk;
	end
	task automatic end_of_test();
		if (errors == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic hang();
		errors++;
		end_of_test();
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("Error at %0t: saw %h, expected %h", $time, s, e);
		end
	endtask
	// request held until the rising edge that takes it; answer taken at its own edge
	task automatic axw(input logic [3:0] a, input logic [31:0] d);
		int i;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		i = 0;
		do @(posedge core_clk); while (!(awready && wready) && ++i < 50);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge core_clk); while (!bvalid && ++i < 100);
		if (i >= 100) hang();
		rsp = bresp;
		bready <= 1'b0;
	endtask
	task automatic axr(input logic [3:0] a);
		int i;
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		i = 0;
		do @(posedge core_clk); while (!arready && ++i < 50);
		arvalid <= 1'b0;
		do @(posedge core_clk); while (!rvalid && ++i < 100);
		if (i >= 100) hang();
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask
	// w set: controller polls until the device reports ready first
	task automatic cmd(input logic [2:0] k, input logic [11:0] p, input logic w);
		int i;
		axw(PAGE_OFFSET, {20'h0, p});
		axw(CTRL_OFFSET, {27'h0, bin, w, k});
		for (i = 0; i < 3000; i++) begin
			axr(STAT_OFFSET);
			if (rd[0] === 1'b0) break;
		end
		if (i >= 3000) hang();
	endtask
	task automatic wrdy();
		int i;
		for (i = 0; i < 5000 && stat[STAT_READY_BIT] !== 1'b1; i++) @(posedge core_clk);
		if (i >= 5000) hang();
	endtask
	task automatic t_regs();
		cmd(K_STATUS, 12'h0, 1'b1);
		axr(STAT_OFFSET);
		chk(rd[15:8], 8'h80);
		axw(4'hc, 32'h1);
		chk(rsp, 2'b10);
		axr(4'hc);
		chk({rsp, rd}, {2'b10, 32'h0});
	endtask
	task automatic t_sect();
		logic [11:0] pg [4] = '{12'h00f, 12'h1ff, 12'h007, 12'h3a5};
		int ix [4] = '{1, 2, 0, 4};
		for (int k = 0; k < 4; k++) begin
			bin <= (k > 1);
			exp[ix[k]] = 1'b1;
			cmd(K_SECT, pg[k], 1'b1);
			repeat (6) @(posedge core_clk);
			chk(stat[STAT_READY_BIT], 1'b0);
			wrdy();
			chk(erased, exp);
		end
	endtask
	task automatic t_fault();
		fault <= 1'b1;
		prot[6] <= 1'b1;
		cmd(K_SECT, 12'h4ff, 1'b1);
		wrdy();
		chk({stat[STAT_EPE_BIT], erased}, {1'b1, exp});
		fault <= 1'b0;
		cmd(K_SECT, 12'h5c0, 1'b1);
		wrdy();
		chk(erased, exp);
	endtask
	// wp asserted mid-erase must not spare sectors already under way
	task automatic t_chip();
		lock[7] <= 1'b1;
		cmd(K_CHIP, 12'h0, 1'b1);
		wp_n <= 1'b0;
		wrdy();
		chk({stat[STAT_EPE_BIT], erased}, {1'b0, 17'h1ff3f});
		wp_n <= 1'b1;
		prot <= '0;
		lock <= '0;
	endtask
	task automatic t_susp();
		cmd(K_SECT, 12'ha00, 1'b1);
		cmd(K_SUSP, 12'h0, 1'b0);
		wrdy();
		chk({stat[STAT_READY_BIT], stat[2:0]}, 4'b1100);
		cmd(K_READ, 12'ha10, 1'b0);
		axr(STAT_OFFSET);
		chk(rd[15:8], UNDEF_BYTE);
		cmd(K_READ, 12'h000, 1'b0);
		axr(STAT_OFFSET);
		chk(rd[15:8], ERASED_BYTE);
		cmd(K_PROG1, 12'ha40, 1'b0);
		repeat (6) @(posedge core_clk);
		chk(stat[STAT_READY_BIT], 1'b1);
		cmd(K_PROG1, 12'hb00, 1'b0);
		cmd(K_SUSP, 12'h0, 1'b0);
		wrdy();
		chk({stat[STAT_READY_BIT], stat[2:0]}, 4'b1101);
		rpin_n <= 1'b0;
		repeat (4) @(posedge core_clk);
		rpin_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk(stat[2:0], 3'b000);
	endtask
	initial begin
		exp = '0;
		repeat (8) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		t_regs();
		t_sect();
		t_fault();
		t_chip();
		t_susp();
		end_of_test();
	end
endmodule
